// *** rtl/dee_pkg.sv ***
package dee_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h0fa6;
  localparam logic [11:0] ADDR_KEY = 12'h0fa7;
  localparam logic [11:0] ADDR_DATA = 12'h0fa8;
  localparam logic [11:0] ADDR_LOC_LO = 12'h0fa9;
  localparam logic [11:0] ADDR_LOC_HI = 12'h0faa;
  // ==========================================================
  // Control register fields
  localparam int BIT_MEM_SPACE = 7;
  localparam int BIT_CFG_SPACE = 6;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_ABORT = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_WR = 1;
  localparam int BIT_RD = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // ==========================================================
  // Array and timing
  localparam int LOC_WIDTH = 10;
  localparam int DEPTH = 1024;
  localparam int CLK_NS = 25;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * 1000 / CLK_NS;
  localparam int PWRUP_TIME_MS = 72;
  localparam int PWRUP_CYCLES = PWRUP_TIME_MS * 1000000 / CLK_NS;
  // ==========================================================
  // Register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dee_req_type;
  typedef enum {ST_IDLE, ST_ERASE, ST_PROG} dee_state_type;
endpackage

// *** rtl/dee_mem.sv ***
`timescale 1ns/1ps
module dee_mem #(
  parameter int AW = 10,
  parameter int DEPTH = 1024
) (
  // Clock
  input wire logic mclk,
  // Access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// *** rtl/dee_timer.sv ***
`timescale 1ns/1ps
module dee_timer #(
  parameter int CYCLES = 160000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  output logic done
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic done_next;
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = 32'(CYCLES);
    end else if (cnt_reg != 32'h0000_0000) begin
      cnt_next = cnt_reg - 32'h0000_0001;
      done_next = (cnt_reg == 32'h0000_0001);
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done <= done_next;
    end
  end
endmodule

// *** rtl/dee_ctrl.sv ***
`timescale 1ns/1ps
//
// Contract
// - 1024 bytes, 10-bit address up to 3FFh
// - Address from high two and low eight
// - High register upper six bits read zero
// - Byte write erases then programs
// - Internal timer times each write
// - Key port reads zero, unlock only
// - Trigger bits set-only, hardware clears
// - Reset mid-write sets abort, zeroes registers; power-on reset clears abort instead
// - Abort keeps space and erase selects
// - Permit clear at power-up only
// - Bit 7 selects program memory
// - Bit 6 selects config, bit 5 zero
// - Bit 4 row erase, cleared when done
// - Read one cycle, refused in program space
// - Read data held until read/write
// - Keys 55h then AAh before trigger
// - Trigger needs permit already set
// - Registers locked during write
// - Write end clears trigger, sets done
// - No writes during power-up timer
module dee_ctrl #(
  parameter int WRITE_CYCLES = dee_pkg::WRITE_CYCLES,
  parameter int PWRUP_CYCLES = dee_pkg::PWRUP_CYCLES
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic por,
  input wire logic ext_rst,
  input wire logic watchdog_timeout,
  // Core register access
  input wire dee_pkg::dee_req_type req,
  output logic [7:0] rdata,
  // Status
  output logic store_done_flag,
  output logic busy
);
  // ==========================================================
  // State
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] lo_reg, lo_next;
  logic [1:0] hi_reg, hi_next;
  logic [1:0] key_reg, key_next;
  logic done_reg, done_next;
  logic [7:0] rdata_next;
  logic rd_pend_reg, rd_pend_next;
  logic [31:0] pwr_reg, pwr_next;
  dee_pkg::dee_state_type st_reg, st_next;
  logic mem_we, tmr_start, tmr_done;
  logic [7:0] mem_wdata, mem_rdata;
  logic [9:0] loc;
  logic hard_rst, wr_active;
  assign hard_rst = sys_rst | por | ext_rst | watchdog_timeout;
  assign loc = {hi_reg, lo_reg};
  assign wr_active = ctrl_reg[dee_pkg::BIT_WR];
  // ==========================================================
  // Leaves
  dee_mem #(.AW(dee_pkg::LOC_WIDTH), .DEPTH(dee_pkg::DEPTH)) u_mem (
    .mclk(mclk),
    .we(mem_we),
    .addr(loc),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );
  dee_timer #(.CYCLES(WRITE_CYCLES)) u_tmr (
    .mclk(mclk),
    .sys_rst(hard_rst),
    .start(tmr_start),
    .done(tmr_done)
  );
  // ==========================================================
  // Next state
  always_comb begin
    logic wr_ctrl, wr_key, wr_data, wr_lo, wr_hi, set_wr;
    wr_ctrl = 1'b0;
    wr_key = 1'b0;
    wr_data = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    set_wr = 1'b0;
    ctrl_next = ctrl_reg;
    data_next = data_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    key_next = key_reg;
    done_next = 1'b0;
    rd_pend_next = 1'b0;
    pwr_next = pwr_reg;
    st_next = st_reg;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    tmr_start = 1'b0;
    rdata_next = 8'h00;
    if (pwr_reg != 32'h0000_0000) begin
      pwr_next = pwr_reg - 32'h0000_0001;
    end
    if (req.wr) begin
      wr_ctrl = (req.addr == dee_pkg::ADDR_CTRL);
      wr_key = (req.addr == dee_pkg::ADDR_KEY);
      wr_data = (req.addr == dee_pkg::ADDR_DATA);
      wr_lo = (req.addr == dee_pkg::ADDR_LOC_LO);
      wr_hi = (req.addr == dee_pkg::ADDR_LOC_HI);
      // Tracker: 0 none, 1 saw first key, 2 saw both
      if (wr_key && req.wdata == dee_pkg::KEY_FIRST) begin
        key_next = 2'd1;
      end else if (wr_key && req.wdata == dee_pkg::KEY_SECOND
                   && key_reg == 2'd1) begin
        key_next = 2'd2;
      end else begin
        key_next = 2'd0;
      end
    end
    // Lock while writing; trigger bits set-only
    if (!wr_active) begin
      if (wr_ctrl) begin
        ctrl_next[dee_pkg::BIT_MEM_SPACE] =
          req.wdata[dee_pkg::BIT_MEM_SPACE];
        ctrl_next[dee_pkg::BIT_CFG_SPACE] =
          req.wdata[dee_pkg::BIT_CFG_SPACE];
        ctrl_next[dee_pkg::BIT_ROW_ERASE] =
          req.wdata[dee_pkg::BIT_ROW_ERASE];
        ctrl_next[dee_pkg::BIT_ABORT] = req.wdata[dee_pkg::BIT_ABORT];
        ctrl_next[dee_pkg::BIT_PERMIT] = req.wdata[dee_pkg::BIT_PERMIT];
        // Permit must already be set; same write with both fails
        set_wr = req.wdata[dee_pkg::BIT_WR] && ctrl_reg[dee_pkg::BIT_PERMIT]
                 && key_reg == 2'd2 && pwr_reg == 32'h0000_0000
                 && !ctrl_reg[dee_pkg::BIT_CFG_SPACE];
        if (set_wr) begin
          ctrl_next[dee_pkg::BIT_WR] = 1'b1;
          tmr_start = 1'b1;
          st_next = dee_pkg::ST_ERASE;
        end else if (req.wdata[dee_pkg::BIT_RD]
                     && !req.wdata[dee_pkg::BIT_MEM_SPACE]
                     && !ctrl_reg[dee_pkg::BIT_MEM_SPACE]) begin
          ctrl_next[dee_pkg::BIT_RD] = 1'b1;
          rd_pend_next = 1'b1;
        end
      end
      if (wr_data) data_next = req.wdata;
      if (wr_lo) lo_next = req.wdata;
      if (wr_hi) hi_next = req.wdata[1:0];
    end
    if (rd_pend_reg) begin
      data_next = mem_rdata;
      ctrl_next[dee_pkg::BIT_RD] = 1'b0;
    end
    case (st_reg)
      dee_pkg::ST_IDLE: begin
      end
      dee_pkg::ST_ERASE: begin
        // Erase phase blanks the cell before programming
        mem_we = !ctrl_reg[dee_pkg::BIT_MEM_SPACE];
        mem_wdata = 8'hff;
        st_next = dee_pkg::ST_PROG;
      end
      dee_pkg::ST_PROG: begin
        if (tmr_done) begin
          mem_we = !ctrl_reg[dee_pkg::BIT_MEM_SPACE]
                   && !ctrl_reg[dee_pkg::BIT_ROW_ERASE];
          mem_wdata = data_reg;
          ctrl_next[dee_pkg::BIT_WR] = 1'b0;
          ctrl_next[dee_pkg::BIT_ROW_ERASE] = 1'b0;
          done_next = 1'b1;
          st_next = dee_pkg::ST_IDLE;
        end
      end
      default: st_next = dee_pkg::ST_IDLE;
    endcase
    // Read mux; key port has no storage
    if (req.rd) begin
      case (req.addr)
        dee_pkg::ADDR_CTRL: rdata_next = ctrl_reg & 8'hdf;
        dee_pkg::ADDR_DATA: rdata_next = data_reg;
        dee_pkg::ADDR_LOC_LO: rdata_next = lo_reg;
        dee_pkg::ADDR_LOC_HI: rdata_next = {6'h00, hi_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end
  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (por) begin
      ctrl_reg <= dee_pkg::CTRL_RESET;
      data_reg <= 8'h00;
      lo_reg <= 8'h00;
      hi_reg <= 2'b00;
      done_reg <= 1'b0;
      pwr_reg <= 32'(PWRUP_CYCLES);
    end else if (sys_rst | ext_rst | watchdog_timeout) begin
      // Space selects and permit kept so a failed store is traceable
      ctrl_reg[dee_pkg::BIT_ABORT] <=
        ctrl_reg[dee_pkg::BIT_ABORT] | wr_active;
      ctrl_reg[dee_pkg::BIT_WR] <= 1'b0;
      ctrl_reg[dee_pkg::BIT_RD] <= 1'b0;
      ctrl_reg[5] <= 1'b0;
      data_reg <= 8'h00;
      lo_reg <= 8'h00;
      hi_reg <= 2'b00;
      done_reg <= 1'b0;
      pwr_reg <= pwr_next;
    end else begin
      ctrl_reg <= ctrl_next;
      data_reg <= data_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      done_reg <= done_next;
      pwr_reg <= pwr_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      key_reg <= 2'd0;
      rd_pend_reg <= 1'b0;
      st_reg <= dee_pkg::ST_IDLE;
      rdata <= 8'h00;
      store_done_flag <= 1'b0;
      busy <= 1'b0;
    end else begin
      key_reg <= key_next;
      rd_pend_reg <= rd_pend_next;
      st_reg <= st_next;
      rdata <= rdata_next;
      store_done_flag <= done_next;
      busy <= ctrl_next[dee_pkg::BIT_WR];
    end
  end
  // Done leaves as a one-cycle set pulse; the sticky flag and its
  // software clear sit in the core's peripheral flag register
  // ==========================================================
  // Checks: unlock and write cycle
  AST_KEY_PATH: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(ctrl_reg[dee_pkg::BIT_WR]) |-> $past(key_reg) == 2'd2)
    else $error("write started without unlock");
  AST_PERMIT: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(ctrl_reg[dee_pkg::BIT_WR])
    |-> $past(ctrl_reg[dee_pkg::BIT_PERMIT]))
    else $error("write started without permit");
  AST_LOCK: assert property (
    @(posedge mclk) disable iff (hard_rst)
    wr_active && $past(wr_active) |-> $stable(lo_reg) && $stable(hi_reg)
    && $stable(data_reg))
    else $error("address or data changed during write");
  AST_ERASE_FIRST: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(wr_active) && !ctrl_reg[dee_pkg::BIT_MEM_SPACE]
    |-> mem_we && mem_wdata == 8'hff)
    else $error("byte not erased before programming");
  // A reset also drops the trigger, so that fall is not a completion
  AST_DONE: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $fell(ctrl_reg[dee_pkg::BIT_WR]) && !$past(hard_rst) |-> done_reg)
    else $error("done not set at write end");
  AST_DONE_PULSE: assert property (
    @(posedge mclk) disable iff (hard_rst)
    store_done_flag |=> !store_done_flag)
    else $error("done flag held past one cycle");
  AST_PWRUP: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(ctrl_reg[dee_pkg::BIT_WR]) |-> $past(pwr_reg) == 32'h0000_0000)
    else $error("write during power-up");
  // ==========================================================
  // Checks: reads and resets
  AST_RD_CLR: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(ctrl_reg[dee_pkg::BIT_RD]) |=> !ctrl_reg[dee_pkg::BIT_RD])
    else $error("read trigger stuck");
  AST_RD_SPACE: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $rose(ctrl_reg[dee_pkg::BIT_RD]) |-> !ctrl_reg[dee_pkg::BIT_MEM_SPACE])
    else $error("read in program space");
  AST_HI_ZERO: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $past(req.rd) && $past(req.addr) == dee_pkg::ADDR_LOC_HI
    |-> rdata[7:2] == 6'h00)
    else $error("high bits not zero");
  AST_KEY_READ: assert property (
    @(posedge mclk) disable iff (hard_rst)
    $past(req.rd) && $past(req.addr) == dee_pkg::ADDR_KEY
    |-> rdata == 8'h00)
    else $error("key port read not zero");
  // Only power-up may drop the permit; other resets must keep it
  AST_PERMIT_KEEP: assert property (
    @(posedge mclk) disable iff (por)
    $past(ctrl_reg[dee_pkg::BIT_PERMIT])
    && !($past(req.wr) && $past(req.addr) == dee_pkg::ADDR_CTRL)
    |-> ctrl_reg[dee_pkg::BIT_PERMIT])
    else $error("store permit cleared by hardware");
  AST_ABORT_SET: assert property (
    @(posedge mclk) disable iff (por)
    $past(ext_rst || watchdog_timeout) && !$past(por) && $past(wr_active)
    |-> ctrl_reg[dee_pkg::BIT_ABORT] && lo_reg == 8'h00
    && hi_reg == 2'b00 && data_reg == 8'h00)
    else $error("aborted write not flagged");
  AST_SEL_KEEP: assert property (
    @(posedge mclk) disable iff (por)
    $past(ext_rst || watchdog_timeout) && !$past(por)
    |-> $stable(ctrl_reg[dee_pkg::BIT_MEM_SPACE])
    && $stable(ctrl_reg[dee_pkg::BIT_ROW_ERASE]))
    else $error("space or erase select lost on reset");
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  localparam int WCYC = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic por = 1'b1;
  logic ext_rst = 1'b0;
  logic watchdog_timeout = 1'b0;
  dee_pkg::dee_req_type req = '0;
  logic [7:0] rdata;
  logic store_done_flag;
  logic busy;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [9:0] a;
  int seed = 32'h8e47_079f;
  int fail_count = 0;
  int checked = 0;

  dee_ctrl #(.WRITE_CYCLES(WCYC), .PWRUP_CYCLES(10)) dee_ctrl_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .por(por),
    .ext_rst(ext_rst),
    .watchdog_timeout(watchdog_timeout),
    .req(req),
    .rdata(rdata),
    .store_done_flag(store_done_flag),
    .busy(busy)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Busy is looked at mid-cycle, clear of the edge that launches it
  task automatic chk_busy(input logic e);
    @(negedge mclk);
    chk({7'h00, busy}, {7'h00, e});
  endtask

  // Strobe stays up into the next call, so key writes are back to back
  task automatic wr(input logic [11:0] ad, input logic [7:0] v);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: v};
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      req <= '0;
    end
  endtask

  task automatic rd(input logic [11:0] ad, input logic [7:0] e);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    exp_q.push_back(e);
    idle(1);
  endtask

  task automatic trigger(input logic [7:0] ctl);
    wr(dee_pkg::ADDR_KEY, dee_pkg::KEY_FIRST);
    wr(dee_pkg::ADDR_KEY, dee_pkg::KEY_SECOND);
    wr(dee_pkg::ADDR_CTRL, ctl);
    idle(2);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (store_done_flag !== 1'b1 && n < 4 * WCYC) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, store_done_flag}, 8'h01);
    @(negedge mclk);
    chk({7'h00, store_done_flag}, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Read-data monitor: answer lands one cycle after the strobe
  always @(posedge mclk) begin
    rd_seen <= req.rd;
  end

  always @(negedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    por <= 1'b0;
    wr(dee_pkg::ADDR_CTRL, 8'h04);
    trigger(8'h06);
    chk_busy(1'b0);
    idle(12);
    rd(dee_pkg::ADDR_CTRL, 8'h04);
    rd(dee_pkg::ADDR_KEY, 8'h00);
    wr(dee_pkg::ADDR_LOC_HI, 8'hff);
    idle(1);
    rd(dee_pkg::ADDR_LOC_HI, 8'h03);
    $display("test powerup and registers done");
    a = 10'($random(seed));
    d = 8'($random(seed));
    wr(dee_pkg::ADDR_LOC_HI, {6'h00, a[9:8]});
    wr(dee_pkg::ADDR_LOC_LO, a[7:0]);
    wr(dee_pkg::ADDR_DATA, d);
    trigger(8'h06);
    chk_busy(1'b1);
    wr(dee_pkg::ADDR_DATA, ~d);
    wr(dee_pkg::ADDR_LOC_LO, ~a[7:0]);
    idle(1);
    rd(dee_pkg::ADDR_DATA, d);
    rd(dee_pkg::ADDR_CTRL, 8'h06);
    wait_done();
    idle(2);
    rd(dee_pkg::ADDR_CTRL, 8'h04);
    wr(dee_pkg::ADDR_DATA, ~d);
    wr(dee_pkg::ADDR_CTRL, 8'h05);
    idle(3);
    rd(dee_pkg::ADDR_DATA, d);
    rd(dee_pkg::ADDR_LOC_HI, {6'h00, a[9:8]});
    $display("test write and read back done");
    // Broken unlocks: wrong key, stray write, permit together, order
    for (int i = 0; i < 4; i++) begin
      wr(dee_pkg::ADDR_CTRL, i == 2 ? 8'h00 : 8'h04);
      wr(dee_pkg::ADDR_KEY, i == 3 ? 8'haa : 8'h55);
      if (i == 1) wr(dee_pkg::ADDR_DATA, d);
      wr(dee_pkg::ADDR_KEY, i == 0 ? 8'h00 : (i == 3 ? 8'h55 : 8'haa));
      wr(dee_pkg::ADDR_CTRL, 8'h06);
      idle(2);
      chk_busy(1'b0);
    end
    wr(dee_pkg::ADDR_DATA, 8'h5a);
    wr(dee_pkg::ADDR_CTRL, 8'h81);
    idle(3);
    rd(dee_pkg::ADDR_DATA, 8'h5a);
    $display("test refusals done");
    for (int i = 0; i < 2; i++) begin
      wr(dee_pkg::ADDR_LOC_LO, 8'h33);
      wr(dee_pkg::ADDR_DATA, 8'h44);
      wr(dee_pkg::ADDR_CTRL, 8'h04);
      trigger(i == 0 ? 8'h06 : 8'h16);
      idle(5);
      if (i == 0) ext_rst <= 1'b1;
      else watchdog_timeout <= 1'b1;
      idle(1);
      ext_rst <= 1'b0;
      watchdog_timeout <= 1'b0;
      idle(1);
      chk_busy(1'b0);
      rd(dee_pkg::ADDR_CTRL, {3'h0, i[0], 4'hc});
      rd(dee_pkg::ADDR_LOC_LO, 8'h00);
      rd(dee_pkg::ADDR_DATA, 8'h00);
    end
    idle(3);
    $display("test aborted writes done");
    report_and_stop();
  end
endmodule
